// [include/cfms_defines.svh]
`ifndef CFMS_DEFINES_SVH
`define CFMS_DEFINES_SVH

// Register offsets and control reset value
`define CFMS_ADDR_CTRL 8'h0c
`define CFMS_ADDR_STAT 8'h20
`define CFMS_CTRL_RST 8'h00

// Control field positions
`define CFMS_ADAPTION_SELECT_HI 7
`define CFMS_ADAPTION_SELECT_LO 6
`define CFMS_ERR_SRC_BIT 5
`define CFMS_LUMA_SEL_BIT 4
`define CFMS_ARCH_HI 3
`define CFMS_ARCH_LO 0
`define CFMS_ARCH_D1_BIT 3

// Datapath widths and buffer depth
`define CFMS_DATA_W 10
`define CFMS_ERR_W 8
`define CFMS_FIFO_DEPTH 8

// Architecture codes, composite or YC
`define CFMS_ARCH_3L 4'h0
`define CFMS_ARCH_3L_01 4'h1
`define CFMS_ARCH_3L_12 4'h2
`define CFMS_ARCH_2L_01 4'h3
`define CFMS_ARCH_FLD_2L 4'h4
`define CFMS_ARCH_FLD 4'h5
`define CFMS_ARCH_FRM_2L 4'h6
`define CFMS_ARCH_FRM 4'h7
// Architecture codes, D1
`define CFMS_ARCH_D1_3L 4'h8
`define CFMS_ARCH_D1_3L_01 4'h9
`define CFMS_ARCH_D1_3L_12 4'ha
`define CFMS_ARCH_D1_3L_02 4'hb
`define CFMS_ARCH_D1_FLD_2L 4'hc
`define CFMS_ARCH_D1_FLD_OR_2L 4'hd
`define CFMS_ARCH_D1_FRM_2L 4'he
`define CFMS_ARCH_D1_FRM 4'hf

`endif

// [include/cfms_pkg.sv]
package cfms_pkg;

  typedef enum logic [1:0] {
    CFMS_ADAPTION_SELECT_LINE = 2'h0,
    CFMS_ADAPTION_SELECT_FIELD_FRAME = 2'h1,
    CFMS_ADAPTION_SELECT_THREE_TAP = 2'h2,
    CFMS_ADAPTION_SELECT_PAL_CHROMA = 2'h3
  } cfms_adaption_select_t;

  typedef enum logic [2:0] {
    CFMS_CAND_THREE_LINE = 3'h0,
    CFMS_CAND_PAIR01 = 3'h1,
    CFMS_CAND_PAIR12 = 3'h2,
    CFMS_CAND_PAIR02 = 3'h3,
    CFMS_CAND_TWO_LINE = 3'h4,
    CFMS_CAND_FIELD = 3'h5,
    CFMS_CAND_FRAME = 3'h6
  } cfms_cand_t;

endpackage : cfms_pkg

// [verification/cfms_comb_select_checker.sv]
`include "cfms_defines.svh"

module cfms_comb_select_checker (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // Stream
  input wire logic i_in_valid,
  input wire logic o_in_ready,
  input wire logic [`CFMS_DATA_W-1:0] i_cand_three_line,
  input wire logic o_out_valid,
  input wire logic i_out_ready,
  input wire logic [`CFMS_DATA_W-1:0] o_comb_out,
  input wire logic [2:0] o_cand
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_srst);

  // Shadow copy, since the body is not visible
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic push_e;

  always_comb begin
    next_ctrl = ctrl;
    if (i_srst) begin
      next_ctrl = `CFMS_CTRL_RST;
    end else if (i_reg_wr && i_reg_addr == `CFMS_ADDR_CTRL) begin
      next_ctrl = i_reg_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    ctrl <= next_ctrl;
  end

  // A push into an empty buffer shows its word next cycle
  assign push_e = i_in_valid && o_in_ready && !o_out_valid;

  chk_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
    else $error("read data not zero");
  chk_ctrl_readback: assert property (i_reg_wr && i_reg_addr == `CFMS_ADDR_CTRL ##1
    i_reg_rd && i_reg_addr == `CFMS_ADDR_CTRL |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("control readback wrong");
  chk_unmapped_zero: assert property (i_reg_rd && i_reg_addr != `CFMS_ADDR_CTRL &&
    i_reg_addr != `CFMS_ADDR_STAT |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_push_shows: assert property (push_e |=> o_out_valid)
    else $error("pushed word not shown");
  chk_out_hold: assert property (o_out_valid && !i_out_ready |=>
    o_out_valid && $stable(o_comb_out) && $stable(o_cand))
    else $error("output changed while stalled");
  chk_reset_empty: assert property ($fell(i_srst) |-> o_in_ready && !o_out_valid)
    else $error("buffer not empty after reset");
  chk_three_tap_only: assert property (
    push_e && ctrl[7:6] == 2'h2 && !ctrl[3] |=> o_cand == 3'h0)
    else $error("three-tap mode chose another comb");
  chk_d1_pair02: assert property (push_e && ctrl[3:0] == 4'hb |=> o_cand == 3'h3)
    else $error("code b wrong comb");
  chk_d1_frame: assert property (push_e && ctrl[3:0] == 4'hf |=> o_cand == 3'h6)
    else $error("code f wrong comb");
  chk_chroma_pass: assert property (
    push_e && ctrl[4:0] == 5'h08 |=> o_comb_out == $past(i_cand_three_line))
    else $error("chroma comb value not passed");

  cov_push: cover property (push_e);
  cov_full: cover property (!o_in_ready);
  cov_stat: cover property (i_reg_rd && i_reg_addr == `CFMS_ADDR_STAT);
endmodule : cfms_comb_select_checker

bind cfms_comb_select cfms_comb_select_checker i_cfms_comb_select_checker (
  .i_clock, .i_srst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
  .i_in_valid, .o_in_ready, .i_cand_three_line, .o_out_valid, .i_out_ready,
  .o_comb_out, .o_cand
);

// [verification/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic i_pal = 1'b0;
  logic i_yc_input = 1'b0;
  logic i_in_valid = 1'b0;
  logic i_out_ready = 1'b0;
  logic [9:0] i_video = 10'h050;
  logic [9:0] c [7];
  logic [7:0] e [8] = '{8'h0a, 8'h14, 8'h05, 8'h01, 8'h01, 8'h1e, 8'h03, 8'h09};
  // Expected comb per code, one nibble each
  logic [63:0] tbl = 64'h6655_3210_6655_4210;
  logic [7:0] o_reg_rdata;
  logic o_in_ready;
  logic o_out_valid;
  logic [9:0] o_comb_out;
  logic [7:0] o_error_lookup_table;
  logic [2:0] o_cand;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;

  cfms_comb_select i_cfms_comb_select (
    .i_clock, .i_srst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .i_pal, .i_yc_input, .i_in_valid, .o_in_ready, .i_video,
    .i_cand_three_line(c[0]), .i_cand_pair01(c[1]), .i_cand_pair12(c[2]),
    .i_cand_pair02(c[3]), .i_cand_two_line(c[4]), .i_cand_field(c[5]),
    .i_cand_frame(c[6]), .i_err_lp01(e[0]), .i_err_lp12(e[1]), .i_err_lp02(e[2]),
    .i_err_hp01(e[3]), .i_err_hp12(e[4]), .i_err_hp02(e[5]), .i_err_field(e[6]),
    .i_err_frame(e[7]), .o_out_valid, .i_out_ready, .o_comb_out,
    .o_error_lookup_table, .o_cand
  );

  always #5 i_clock = ~i_clock;

  // Generous ceiling, the run needs well under a thousand cycles
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      print_verdict();
    end
  end

  task print_verdict;
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Leaves the strobe up so a read may follow with no gap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_wr <= 1'b1;
    i_reg_rd <= 1'b0;
    i_reg_addr <= a;
    i_reg_wdata <= d;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1;
    cmp({2'h0, o_reg_rdata}, {2'h0, x});
  endtask : rd

  task automatic pix(input logic [7:0] ctl, input logic [2:0] ec, input logic [7:0] ee);
    logic [9:0] ex;
    ex = ctl[4] ? i_video - c[ec] : c[ec];
    wr(8'h0c, ctl);
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    i_in_valid <= 1'b1;
    @(posedge i_clock);
    i_in_valid <= 1'b0;
    i_out_ready <= 1'b1;
    #1;
    cmp({9'h0, o_out_valid}, 10'h1);
    cmp({7'h0, o_cand}, {7'h0, ec});
    cmp({2'h0, o_error_lookup_table}, {2'h0, ee});
    cmp(o_comb_out, ex);
    @(posedge i_clock);
    i_out_ready <= 1'b0;
  endtask : pix

  task automatic t_regs;
    rd(8'h0c, 8'h00);
    wr(8'h0c, 8'h5a);
    rd(8'h0c, 8'h5a);
    wr(8'h0d, 8'hff);
    rd(8'h0d, 8'h00);
    rd(8'h0c, 8'h5a);
    rd(8'h20, 8'h00);
  endtask : t_regs

  // PAL for composite codes so adaption leaves the decode alone
  task automatic t_arch;
    for (int k = 0; k < 16; k++) begin
      @(posedge i_clock);
      i_pal <= (k < 8);
      pix(8'(k), tbl[4*k +: 3], (k < 8) ? 8'h23 : 8'h0b);
    end
  endtask : t_arch

  task automatic t_adaption_select;
    @(posedge i_clock);
    i_pal <= 1'b0;
    pix(8'h00, 3'h1, 8'h0b);
    pix(8'h40, 3'h5, 8'h0b);
    pix(8'h83, 3'h0, 8'h15);
    pix(8'hc3, 3'h4, 8'h0b);
    @(posedge i_clock);
    i_pal <= 1'b1;
    pix(8'hc0, 3'h1, 8'h23);
    pix(8'h83, 3'h0, 8'h23);
  endtask : t_adaption_select

  task automatic t_yc;
    @(posedge i_clock);
    i_pal <= 1'b0;
    i_yc_input <= 1'b1;
    pix(8'h30, 3'h0, 8'h0a);
    pix(8'h10, 3'h1, 8'h0b);
  endtask : t_yc

  task automatic t_fifo;
    wr(8'h0c, 8'h80);
    repeat (10) begin
      @(posedge i_clock);
      i_reg_wr <= 1'b0;
      i_in_valid <= 1'b1;
    end
    @(posedge i_clock);
    i_in_valid <= 1'b0;
    #1;
    cmp({9'h0, o_in_ready}, 10'h0);
    rd(8'h20, 8'h08);
    @(posedge i_clock);
    i_out_ready <= 1'b1;
    repeat (8) @(posedge i_clock);
    i_out_ready <= 1'b0;
    #1;
    cmp({9'h0, o_out_valid}, 10'h0);
    cmp({9'h0, o_in_ready}, 10'h1);
  endtask : t_fifo

  initial begin
    for (int k = 0; k < 7; k++) begin
      c[k] = 10'h100 + 10'(k);
    end
    repeat (20) @(posedge i_clock);
    i_srst <= 1'b0;
    t_regs();
    t_arch();
    t_adaption_select();
    t_yc();
    t_fifo();
    print_verdict();
  end
endmodule : tb_top

// [verilog/cfms_comb_select.sv]
// Decided for this implementation: the strobed register port.

`include "cfms_defines.svh"

module cfms_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = `CFMS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data,
  // Fill level
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data = mem[rd_ptr];
  assign o_level = count;
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  // Depth is a power of two, so pointers wrap naturally
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = wr_ptr + AW'(1);
    end
    if (pop) begin
      next_rd_ptr = rd_ptr + AW'(1);
    end
    case ({push, pop})
      2'b10: next_count = count + (AW+1)'(1);
      2'b01: next_count = count - (AW+1)'(1);
      default: next_count = count;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage needs no reset; empty flag hides stale words
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

endmodule : cfms_fifo

module cfms_comb_select
  import cfms_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Video standard
  input wire logic i_pal,
  input wire logic i_yc_input,
  // Pixel stream in
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [`CFMS_DATA_W-1:0] i_video,
  input wire logic [`CFMS_DATA_W-1:0] i_cand_three_line,
  input wire logic [`CFMS_DATA_W-1:0] i_cand_pair01,
  input wire logic [`CFMS_DATA_W-1:0] i_cand_pair12,
  input wire logic [`CFMS_DATA_W-1:0] i_cand_pair02,
  input wire logic [`CFMS_DATA_W-1:0] i_cand_two_line,
  input wire logic [`CFMS_DATA_W-1:0] i_cand_field,
  input wire logic [`CFMS_DATA_W-1:0] i_cand_frame,
  // Comb error signals
  input wire logic [`CFMS_ERR_W-1:0] i_err_lp01,
  input wire logic [`CFMS_ERR_W-1:0] i_err_lp12,
  input wire logic [`CFMS_ERR_W-1:0] i_err_lp02,
  input wire logic [`CFMS_ERR_W-1:0] i_err_hp01,
  input wire logic [`CFMS_ERR_W-1:0] i_err_hp12,
  input wire logic [`CFMS_ERR_W-1:0] i_err_hp02,
  input wire logic [`CFMS_ERR_W-1:0] i_err_field,
  input wire logic [`CFMS_ERR_W-1:0] i_err_frame,
  // Pixel stream out
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [`CFMS_DATA_W-1:0] o_comb_out,
  output logic [`CFMS_ERR_W-1:0] o_error_lookup_table,
  output logic [2:0] o_cand
);
  localparam int DW = `CFMS_DATA_W;
  localparam int EW = `CFMS_ERR_W;
  localparam int FW = 3 + EW + DW;
  localparam int LW = $clog2(`CFMS_FIFO_DEPTH) + 1;

  // Saturating error sum; low-pass alone when asked
  function automatic logic [EW-1:0] pair_err(
    input logic [EW-1:0] lp,
    input logic [EW-1:0] hp,
    input logic lp_only
  );
    logic [EW:0] sum;
    sum = {1'b0, lp} + {1'b0, hp};
    if (lp_only) begin
      pair_err = lp;
    end else if (sum[EW]) begin
      pair_err = '1;
    end else begin
      pair_err = sum[EW-1:0];
    end
  endfunction : pair_err

  // Ties go to the first operand
  function automatic logic first_lower(
    input logic [EW-1:0] ea,
    input logic [EW-1:0] eb
  );
    first_lower = (ea <= eb);
  endfunction : first_lower

  logic [7:0] filter_mode_control;
  logic [7:0] next_filter_mode_control;
  logic [7:0] reg_rdata;
  logic [7:0] next_reg_rdata;
  cfms_cand_t last_cand;
  cfms_cand_t next_last_cand;

  cfms_adaption_select_t adaption_select;
  logic yc_error_source;
  logic luma_chroma_select;
  logic [3:0] arch;
  logic yc_luma;
  logic [EW-1:0] err01;
  logic [EW-1:0] err12;
  logic [EW-1:0] err02;
  logic [EW-1:0] lut_err;
  cfms_cand_t cand;
  logic [DW-1:0] chroma;
  logic [DW-1:0] comb_val;

  logic fifo_ready;
  logic fifo_push;
  logic [FW-1:0] fifo_out;
  logic [LW-1:0] fifo_level;

  assign adaption_select = cfms_adaption_select_t'(
    filter_mode_control[`CFMS_ADAPTION_SELECT_HI:`CFMS_ADAPTION_SELECT_LO]);
  assign yc_error_source = filter_mode_control[`CFMS_ERR_SRC_BIT];
  assign luma_chroma_select = filter_mode_control[`CFMS_LUMA_SEL_BIT];
  assign arch = filter_mode_control[`CFMS_ARCH_HI:`CFMS_ARCH_LO];

  // Register file
  always_comb begin
    next_filter_mode_control = filter_mode_control;
    next_reg_rdata = 8'h00;
    if (i_reg_wr && (i_reg_addr == `CFMS_ADDR_CTRL)) begin
      next_filter_mode_control = i_reg_wdata;
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        `CFMS_ADDR_CTRL: next_reg_rdata = filter_mode_control;
        `CFMS_ADDR_STAT: next_reg_rdata = {1'b0, last_cand, fifo_level};
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      filter_mode_control <= `CFMS_CTRL_RST;
      reg_rdata <= 8'h00;
    end else begin
      filter_mode_control <= next_filter_mode_control;
      reg_rdata <= next_reg_rdata;
    end
  end

  assign o_reg_rdata = reg_rdata;

  // Lookup table error pairs
  always_comb begin
    yc_luma = i_yc_input & luma_chroma_select;
    err01 = pair_err(i_err_lp01, i_err_hp01, yc_luma & yc_error_source);
    err12 = pair_err(i_err_lp12, i_err_hp12, yc_luma & yc_error_source);
    err02 = pair_err(i_err_lp02, i_err_hp02, yc_luma & yc_error_source);
    if (i_pal) begin
      lut_err = err02;
    end else if (adaption_select == CFMS_ADAPTION_SELECT_THREE_TAP) begin
      lut_err = first_lower(err01, err12) ? err12 : err01;
    end else begin
      lut_err = first_lower(err01, err12) ? err01 : err12;
    end
  end

  // Architecture decode, then adaption override
  always_comb begin
    case (arch)
      `CFMS_ARCH_3L: cand = CFMS_CAND_THREE_LINE;
      `CFMS_ARCH_3L_01: cand = CFMS_CAND_PAIR01;
      `CFMS_ARCH_3L_12: cand = CFMS_CAND_PAIR12;
      `CFMS_ARCH_2L_01: cand = CFMS_CAND_TWO_LINE;
      `CFMS_ARCH_FLD_2L: cand = CFMS_CAND_FIELD;
      `CFMS_ARCH_FLD: cand = CFMS_CAND_FIELD;
      `CFMS_ARCH_FRM_2L: cand = CFMS_CAND_FRAME;
      `CFMS_ARCH_FRM: cand = CFMS_CAND_FRAME;
      `CFMS_ARCH_D1_3L: cand = CFMS_CAND_THREE_LINE;
      `CFMS_ARCH_D1_3L_01: cand = CFMS_CAND_PAIR01;
      `CFMS_ARCH_D1_3L_12: cand = CFMS_CAND_PAIR12;
      `CFMS_ARCH_D1_3L_02: cand = CFMS_CAND_PAIR02;
      `CFMS_ARCH_D1_FLD_2L: cand = CFMS_CAND_FIELD;
      `CFMS_ARCH_D1_FLD_OR_2L: begin
        cand = first_lower(i_err_field, err01) ?
          CFMS_CAND_FIELD : CFMS_CAND_TWO_LINE;
      end
      `CFMS_ARCH_D1_FRM_2L: cand = CFMS_CAND_FRAME;
      `CFMS_ARCH_D1_FRM: cand = CFMS_CAND_FRAME;
      default: cand = CFMS_CAND_THREE_LINE;
    endcase
    // D1 codes bypass adaption: no composite standard to adaption_select on
    if (!arch[`CFMS_ARCH_D1_BIT]) begin
      case (adaption_select)
        CFMS_ADAPTION_SELECT_LINE: begin
          if (!i_pal) begin
            if (first_lower(err02, err01) && first_lower(err02, err12)) begin
              cand = CFMS_CAND_THREE_LINE;
            end else if (first_lower(err01, err12)) begin
              cand = CFMS_CAND_PAIR01;
            end else begin
              cand = CFMS_CAND_PAIR12;
            end
          end
        end
        CFMS_ADAPTION_SELECT_FIELD_FRAME: begin
          if (!i_pal) begin
            cand = first_lower(i_err_field, i_err_frame) ?
              CFMS_CAND_FIELD : CFMS_CAND_FRAME;
          end
        end
        CFMS_ADAPTION_SELECT_THREE_TAP: cand = CFMS_CAND_THREE_LINE;
        CFMS_ADAPTION_SELECT_PAL_CHROMA: begin
          if (i_pal) begin
            cand = first_lower(err01, err12) ?
              CFMS_CAND_PAIR01 : CFMS_CAND_PAIR12;
          end
        end
        default: cand = CFMS_CAND_THREE_LINE;
      endcase
    end
  end

  // Candidates carry chroma; luma is the video less that chroma
  always_comb begin
    case (cand)
      CFMS_CAND_THREE_LINE: chroma = i_cand_three_line;
      CFMS_CAND_PAIR01: chroma = i_cand_pair01;
      CFMS_CAND_PAIR12: chroma = i_cand_pair12;
      CFMS_CAND_PAIR02: chroma = i_cand_pair02;
      CFMS_CAND_TWO_LINE: chroma = i_cand_two_line;
      CFMS_CAND_FIELD: chroma = i_cand_field;
      CFMS_CAND_FRAME: chroma = i_cand_frame;
      default: chroma = i_cand_three_line;
    endcase
    comb_val = luma_chroma_select ? DW'(i_video - chroma) : chroma;
  end

  // Last decision, for software to watch
  assign fifo_push = i_in_valid & fifo_ready;

  always_comb begin
    next_last_cand = last_cand;
    if (fifo_push) begin
      next_last_cand = cand;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      last_cand <= CFMS_CAND_THREE_LINE;
    end else begin
      last_cand <= next_last_cand;
    end
  end

  // Buffer absorbs output stalls; a full buffer stalls the input
  cfms_fifo #(
    .WIDTH(FW),
    .DEPTH(`CFMS_FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_valid(i_in_valid),
    .o_ready(fifo_ready),
    .i_data({cand, lut_err, comb_val}),
    .o_valid(o_out_valid),
    .i_ready(i_out_ready),
    .o_data(fifo_out),
    .o_level(fifo_level)
  );

  assign o_in_ready = fifo_ready;
  assign o_cand = fifo_out[FW-1:EW+DW];
  assign o_error_lookup_table = fifo_out[EW+DW-1:DW];
  assign o_comb_out = fifo_out[DW-1:0];

endmodule : cfms_comb_select
